// File: design/bpf_pkg.sv
// Purpose: Shared types and constants for the bridge protection and fault report block
// Assumes: One 25 MHz system clock, synchronous active-high reset
// Notes: Analog comparators sit outside; their results arrive as digital levels
`default_nettype none
package bpf_pkg;
    // Number of half-bridges
    localparam int unsigned BPF_NUM_BRIDGES = 3;
    // System clock period in ns
    localparam int unsigned BPF_CLK_PERIOD_NS = 40;
    // Brief high-side off time for one bootstrap recharge, in ns
    localparam int unsigned BPF_RECHARGE_NS = 200;
    // Recharge pulse length in cycles, least time rounded up
    localparam int unsigned BPF_RECHARGE_CYC = (BPF_RECHARGE_NS + BPF_CLK_PERIOD_NS - 1) / BPF_CLK_PERIOD_NS;
    // Width of the recharge counter
    localparam int unsigned BPF_RCH_W = 4;
    // Recharge counter load value
    localparam logic [BPF_RCH_W-1:0] BPF_RCH_LOAD = BPF_RCH_W'(BPF_RECHARGE_CYC);
    // Counter zero value
    localparam logic [BPF_RCH_W-1:0] BPF_RCH_ZERO = 4'h0;

    // Per-bridge gate command towards the output stage
    typedef struct packed {
        logic hs_on;    // High-side transistor on
        logic ls_on;    // Low-side transistor on
        logic weak_pd;  // Weak pulldown on the output
    } bpf_gate_t;

    // Per-bridge analog condition flags, already sampled
    typedef struct packed {
        logic gate_ok;   // Gate-drive supply above threshold
        logic boot_ok;   // Bootstrap capacitor adequately charged
        logic cur_trip;  // Overcurrent shutdown detector
    } bpf_sense_t;

    // Power-up sequencing state
    typedef enum logic [1:0] {
        BPF_ST_OFF,
        BPF_ST_RUN
    } bpf_state_t;
endpackage
`default_nettype wire

// File: design/bpf_core.sv
// Purpose: Protection, shutdown latching and alarm/warning reporting for three half-bridges
// Assumes: Comparator levels and reset pins are asynchronous and are synchronised here
// Notes: Open-drain outputs use an enable that is low while the pin is pulled low
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - Outputs high impedance until supplies valid
// R2 - Weak pulldown while resets held low
// R3 - Controller holds resets low at power-down
// R4 - Fully operational while supplies above threshold
// R5 - Alarm and warning active-low open-drain
// R6 - Every shutdown fault pulls alarm low
// R7 - Warning low above warning temperature
// R8 - Alarm/warning pair encodes device status
// R9 - Fault: outputs high impedance, alarm low
// R10 - Other faults recover automatically
// R11 - Controller waits before reset recovery
// R12 - Low bootstrap forces brief high-side off
// R13 - Recharge may trigger on short off time
// R14 - Controller keeps low side on minimum
// R15 - Reset low forces bridge high impedance
// R16 - Reset rising edge clears bridge latch
// R17 - Thermal latch needs all three edges
// R18 - Alarm released only when fully clear
module bpf_core
    import bpf_pkg::*;
#(
    parameter int unsigned NB = BPF_NUM_BRIDGES  // Half-bridge count
) (
    input wire logic clk_sys,                      // 25 MHz system clock
    input wire logic rst,                          // Synchronous reset, active high
    input wire logic [NB-1:0] bridge_reset_n,      // Per-bridge reset pins, active low
    input wire logic [NB-1:0] pwm_in,              // Per-bridge PWM command pins
    input wire logic [NB-1:0] gate_drive_supply,   // Gate supply above threshold, per bridge
    input wire logic common_supply_ok,             // Common supply above threshold
    input wire logic [NB-1:0] bootstrap_pin,       // Bootstrap charge adequate, per bridge
    input wire logic [NB-1:0] current_shutdown,    // Overcurrent detector, per bridge
    input wire logic temp_warn,                    // Junction above warning level
    input wire logic thermal_shutdown,             // Junction above shutdown level
    output logic [NB-1:0] hs_on,                   // High-side gate drive
    output logic [NB-1:0] ls_on,                   // Low-side gate drive
    output logic [NB-1:0] weak_pd,                 // Weak output pulldown enable
    output logic fault_n_o,                        // Alarm pin output value
    output logic fault_n_oe_n,                     // Alarm pin enable, low drives
    output logic thermal_warning_n_o,              // Warning pin output value
    output logic thermal_warning_n_oe_n            // Warning pin enable, low drives
);

    //////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int unsigned SW = 4 * NB + 3;  // Synchronised bit count
    logic [SW-1:0] sync1_q;                     // First stage, read only by second
    logic [SW-1:0] sync2_q;                     // Second stage, safe to use
    wire logic [SW-1:0] raw_in = {bridge_reset_n, pwm_in, gate_drive_supply, current_shutdown,
                                  common_supply_ok, temp_warn, thermal_shutdown};

    // Two-flop synchroniser for all pin levels except bootstrap
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic [NB-1:0] boot_s1_q;  // Bootstrap first stage
    logic [NB-1:0] boot_s2_q;  // Bootstrap second stage

    // Bootstrap level synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            boot_s1_q <= '0;
            boot_s2_q <= '0;
        end else begin
            boot_s1_q <= bootstrap_pin;
            boot_s2_q <= boot_s1_q;
        end
    end

    // Named views of synchronised levels
    wire logic [NB-1:0] rstn_s = sync2_q[4*NB+2 -: NB];
    wire logic [NB-1:0] pwm_s = sync2_q[3*NB+2 -: NB];
    wire logic [NB-1:0] gate_s = sync2_q[2*NB+2 -: NB];
    wire logic [NB-1:0] oc_s = sync2_q[NB+2 -: NB];
    wire logic vdd_s = sync2_q[2];
    wire logic warn_s = sync2_q[1];
    wire logic thermal_shutdown_s = sync2_q[0];

    //////////////////////////////////////////////////////////////////////////
    // Reset edge detection and supply state
    logic [NB-1:0] rstn_prev_q;   // Previous reset level
    logic [NB-1:0] thermal_shutdown_seen_q;   // Rising edges seen since thermal shutdown
    logic [NB-1:0] oc_latch_q;    // Overcurrent shutdown latch per bridge
    logic thermal_shutdown_latch_q;           // Thermal shutdown latch
    bpf_state_t state_q;          // Power-up state
    bpf_state_t state_d;          // Next power-up state

    wire logic [NB-1:0] rstn_rise = rstn_s & ~rstn_prev_q;
    // R1 supplies valid check
    wire logic supplies_ok = vdd_s & (&gate_s);
    // R17 all edges gathered
    wire logic thermal_shutdown_clear = &(thermal_shutdown_seen_q | rstn_rise);

    // R1 R4 R10 run only while supplies valid, resume on recovery
    always_comb begin
        state_d = state_q;
        case (state_q)
            BPF_ST_OFF: begin
                if (supplies_ok) state_d = BPF_ST_RUN;
            end
            BPF_ST_RUN: begin
                if (!supplies_ok) state_d = BPF_ST_OFF;
            end
            default: state_d = BPF_ST_OFF;
        endcase
    end

    // Thermal latch and edge bookkeeping
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= BPF_ST_OFF;
            rstn_prev_q <= '0;
            thermal_shutdown_latch_q <= 1'b0;
            thermal_shutdown_seen_q <= '0;
        end else begin
            state_q <= state_d;
            rstn_prev_q <= rstn_s;
            // R17 set wins; clear after all three edges
            if (thermal_shutdown_s) begin
                thermal_shutdown_latch_q <= 1'b1;
                thermal_shutdown_seen_q <= '0;
            end else if (thermal_shutdown_latch_q && thermal_shutdown_clear) begin
                thermal_shutdown_latch_q <= 1'b0;
                thermal_shutdown_seen_q <= '0;
            end else if (thermal_shutdown_latch_q) begin
                thermal_shutdown_seen_q <= thermal_shutdown_seen_q | rstn_rise;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Per-bridge latch, recharge guard and gate drive
    wire logic running = (state_q == BPF_ST_RUN);
    // R9 shutdown cause active now, cut without waiting a cycle
    wire logic shut_now = ~supplies_ok | thermal_shutdown_s;
    // R1 R17 not yet powered up, or thermal latch still held
    wire logic shut_held = ~running | thermal_shutdown_latch_q;
    // Recharge counter decrement step
    localparam logic [BPF_RCH_W-1:0] RCH_STEP = BPF_RCH_W'(4'h1);
    bpf_gate_t [NB-1:0] gate_d;   // Next gate commands
    logic [NB-1:0] bridge_off;    // Bridge forced to high impedance

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_br
            logic [BPF_RCH_W-1:0] rch_q;  // Recharge interval counter
            wire logic recharging = (rch_q != BPF_RCH_ZERO);
            // R12 R13 low bootstrap while high side requested
            wire logic boot_low = ~boot_s2_q[gi] & pwm_s[gi];

            // R15 R9 reset low or any fault gives high impedance
            assign bridge_off[gi] = shut_now | shut_held | ~rstn_s[gi] | oc_latch_q[gi] | oc_s[gi];
            assign gate_d[gi].hs_on = ~bridge_off[gi] & pwm_s[gi] & ~recharging & ~boot_low;
            assign gate_d[gi].ls_on = ~bridge_off[gi] & (~pwm_s[gi] | recharging | boot_low);
            // R2 weak pulldown while reset held low
            assign gate_d[gi].weak_pd = ~rstn_s[gi];

            // Overcurrent latch and recharge counter
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    oc_latch_q[gi] <= 1'b0;
                    rch_q <= BPF_RCH_ZERO;
                end else begin
                    // R16 set wins over rising-edge clear
                    if (oc_s[gi]) oc_latch_q[gi] <= 1'b1;
                    else if (rstn_rise[gi]) oc_latch_q[gi] <= 1'b0;
                    // R12 load a recharge interval
                    if (boot_low && !recharging && !bridge_off[gi]) rch_q <= BPF_RCH_LOAD;
                    else if (recharging) rch_q <= rch_q - RCH_STEP;
                end
            end

            // Registered gate outputs
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    hs_on[gi] <= 1'b0;
                    ls_on[gi] <= 1'b0;
                    weak_pd[gi] <= 1'b0;
                end else begin
                    hs_on[gi] <= gate_d[gi].hs_on;
                    ls_on[gi] <= gate_d[gi].ls_on;
                    weak_pd[gi] <= gate_d[gi].weak_pd;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Alarm and warning pins
    // R6 R18 any active or latched shutdown condition
    wire logic alarm = ~supplies_ok | thermal_shutdown_latch_q | thermal_shutdown_s | (|oc_latch_q) | (|oc_s);

    // R5 R7 R8 open-drain active-low reporting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_n_o <= 1'b0;
            fault_n_oe_n <= 1'b1;
            thermal_warning_n_o <= 1'b0;
            thermal_warning_n_oe_n <= 1'b1;
        end else begin
            fault_n_o <= 1'b0;
            fault_n_oe_n <= ~alarm;
            thermal_warning_n_o <= 1'b0;
            thermal_warning_n_oe_n <= ~warn_s;
        end
    end

endmodule
`default_nettype wire

// File: sim/bpf_ctrl_model.sv
// Purpose: Controller model driving reset and PWM pins
// Assumes: Commands come from the bench
// Notes: Pins change only after a clock edge
`default_nettype none
module bpf_ctrl_model (
    input wire logic clk_sys, // Clock
    input wire logic [2:0] pwm_cmd, // Wanted PWM
    input wire logic [2:0] hold_cmd, // Bridges held in reset
    output logic [2:0] bridge_reset_n = 3'h0, // Reset pins
    output logic [2:0] pwm_in = 3'h0 // PWM pins
);
    // resets held low, PWM low while held
    always @(posedge clk_sys) begin
        bridge_reset_n <= ~hold_cmd;
        pwm_in <= pwm_cmd & ~hold_cmd;
    end
endmodule
`default_nettype wire

// File: sim/bpf_core_sva.sv
// Purpose: Port assertions for the protection block
// Assumes: Inputs reach outputs three edges later
// Notes: Bound to every bpf_core instance
`default_nettype none
module bpf_core_sva #(
    parameter int unsigned NB = 3 // Bridge count
) (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic [NB-1:0] bridge_reset_n, // Reset pins
    input wire logic [NB-1:0] pwm_in, // PWM pins
    input wire logic [NB-1:0] gate_drive_supply, // Gate supplies
    input wire logic common_supply_ok, // Common supply
    input wire logic [NB-1:0] bootstrap_pin, // Bootstrap ok
    input wire logic [NB-1:0] current_shutdown, // Overcurrent
    input wire logic temp_warn, // Warm
    input wire logic thermal_shutdown, // Too hot
    input wire logic [NB-1:0] hs_on, // High side
    input wire logic [NB-1:0] ls_on, // Low side
    input wire logic [NB-1:0] weak_pd, // Pulldown
    input wire logic fault_n_o, // Alarm value
    input wire logic fault_n_oe_n, // Alarm enable
    input wire logic thermal_warning_n_o, // Warning value
    input wire logic thermal_warning_n_oe_n // Warning enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_od_low_only: assert property (!fault_n_o && !thermal_warning_n_o) else $error("pin drives high");
    a_ocp_alarm_off: assert property ($rose(current_shutdown[0]) |->
        ##3 !fault_n_oe_n && !hs_on[0] && !ls_on[0]) else $error("overcurrent not reported");
    a_therm_all_off: assert property ($rose(thermal_shutdown) |->
        ##3 !fault_n_oe_n && hs_on == '0 && ls_on == '0) else $error("thermal not reported");
    a_uv_all_off: assert property (!common_supply_ok |->
        ##3 !fault_n_oe_n && hs_on == '0 && ls_on == '0) else $error("undervoltage not off");
    a_warn_track: assert property (temp_warn |-> ##3 !thermal_warning_n_oe_n) else $error("warning missing");
    a_warn_clear: assert property (!temp_warn |-> ##3 thermal_warning_n_oe_n) else $error("warning stuck");
    a_rst_pin_hiz: assert property (!bridge_reset_n[1] |->
        ##3 !hs_on[1] && !ls_on[1] && weak_pd[1]) else $error("held bridge drives");
    a_boot_hs_off: assert property (pwm_in[2] && !bootstrap_pin[2] |-> ##3 !hs_on[2]) else $error("no recharge");
    a_ocp_stays_latched: assert property ($fell(current_shutdown[0]) ##1 bridge_reset_n[0] [*4] |->
        !fault_n_oe_n) else $error("overcurrent self cleared");
    a_alarm_release: assert property ($rose(fault_n_oe_n) |->
        $past(common_supply_ok, 3) && !$past(thermal_shutdown, 3) && $past(gate_drive_supply, 3) == '1
        && $past(current_shutdown, 3) == '0) else $error("early release");
    c_alarm_set: cover property ($fell(fault_n_oe_n));
    c_alarm_clear: cover property ($rose(fault_n_oe_n));
    c_warn_only: cover property (fault_n_oe_n && !thermal_warning_n_oe_n);
endmodule
bind bpf_core bpf_core_sva #(.NB(NB)) u_sva (.*);
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the protection block
// Assumes: Outputs settle within twelve cycles
// Notes: Expected status is queued, a monitor compares
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0; // Clock
    logic rst = 1'h1; // Reset
    logic [2:0] pwm = 3'h0, hold = 3'h7, gds = 3'h7, boot = 3'h7, ocp = 3'h0; // Driven levels
    logic cs = 1'h1, tw = 1'h0, ts = 1'h0; // Driven levels
    logic [2:0] ocl = 3'h0, seen = 3'h7; // Latch bookkeeping
    logic thl = 1'h0; // Thermal latch
    logic [2:0] rst_n_w, pwm_w, hs_w, ls_w, pd_w; // Pins
    logic fo, foe_n, wo, woe_n; // Alarm pins
    logic [10:0] exp_q[$]; // Expected status
    logic [10:0] want; // Expected
    int mismatches = 0, n_compared = 0; // Counts
    event chk; // Result ready
    always #20 clk_sys = ~clk_sys;
    bpf_ctrl_model u_ctrl (.clk_sys(clk_sys), .pwm_cmd(pwm), .hold_cmd(hold), .bridge_reset_n(rst_n_w),
        .pwm_in(pwm_w));
    bpf_core dut (.clk_sys(clk_sys), .rst(rst), .bridge_reset_n(rst_n_w), .pwm_in(pwm_w), .gate_drive_supply(gds),
        .common_supply_ok(cs), .bootstrap_pin(boot), .current_shutdown(ocp), .temp_warn(tw),
        .thermal_shutdown(ts), .hs_on(hs_w), .ls_on(ls_w), .weak_pd(pd_w), .fault_n_o(fo),
        .fault_n_oe_n(foe_n), .thermal_warning_n_o(wo), .thermal_warning_n_oe_n(woe_n));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Apply levels, track latches, queue the expected status
    task automatic step(input logic [2:0] p, h, g, b, o, input logic c, w, s);
        logic [2:0] off;
        seen = s ? 3'h0 : seen | (hold & ~h);
        ocl = (ocl & ~(hold & ~h)) | o;
        thl = s | (thl & seen != 3'h7);
        @(posedge clk_sys);
        {pwm, hold, gds, boot, ocp, cs, tw, ts} <= {p, h, g, b, o, c, w, s};
        off = h | ocl | {3{~c | g != 3'h7 | thl}};
        exp_q.push_back({~(|ocl | ~c | g != 3'h7 | thl), ~w, p & b & ~off, (~p | ~b) & ~off, h});
        repeat (12) @(posedge clk_sys);
        #1 -> chk;
        $display("test %0d done", n_compared);
    endtask
    // Monitor takes the oldest note per result
    initial forever begin
        @chk;
        want = exp_q.pop_front();
        n_compared++;
        if ({foe_n, woe_n, hs_w, ls_w, pd_w} !== want) begin
            mismatches++;
            $display("Error t=%0t exp=%h got=%h", $time, want, {foe_n, woe_n, hs_w, ls_w, pd_w});
        end
        if ({fo, wo} !== 2'h0) begin
            mismatches++;
            $display("Error t=%0t exp=%h got=%h", $time, 2'h0, {fo, wo});
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hC70DEEE3));
        repeat (9) @(posedge clk_sys);
        exp_q.push_back(11'h600);
        #1 -> chk;
        @(posedge clk_sys);
        rst <= 1'h0;
        step(3'h0, 3'h7, 3'h7, 3'h7, 3'h0, 1'h0, 1'h0, 1'h0);
        step(3'h5, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h2, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h1, 1'h0);
        step(3'h2, 3'h0, 3'h5, 3'h7, 3'h0, 1'h1, 1'h1, 1'h0);
        step(3'h2, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h7, 3'h0, 3'h7, 3'h7, 3'h1, 1'h1, 1'h0, 1'h0);
        step(3'h7, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h7, 3'h1, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h7, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h6, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h1, 1'h1);
        step(3'h6, 3'h3, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h6, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h6, 3'h4, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h6, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h4, 3'h0, 3'h7, 3'h3, 3'h0, 1'h1, 1'h0, 1'h0);
        step(3'h4, 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        repeat (8) step(3'($urandom), 3'h0, 3'h7, 3'h7, 3'h0, 1'h1, 1'h0, 1'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
